/* File: hdl/psc_core.sv */
// Positioning sequence controller: loop approach, speeds, torques, blocking, readjust.
// Assumes an Avalon-MM master, a motion stage that follows drive_cmd and reports
// speed, encoder position and motor power synchronously to core_clk.
// How it works
// - Target against loop direction: overshoot by loop length, then final approach.
// - Forward loop, target above actual: go straight to it.
// - Forward loop, target below: reverse to target minus loop, then forward.
// - Target slightly ahead after loopless move: back off so final travel is loop length.
// - At target compare with absolute encoder; mismatch sets status bit 9.
// - Loop length resets to minus 250, forward approach.
// - Refuse upper limit target with positive loop, lower with negative.
// - No-loop mode approaches every target directly.
// - Manual speed for jog, positioning speed for runs; accel and decel limits.
// - Deceleration shrinks progressively during final approach.
// - Stop brakes at maximum deceleration, ignoring the decel setting.
// - Starting torque for start time after each start, then driving torque.
// - Slow beyond blocking time aborts, sets position error, holds torque.
// - After blocking, new target value starts a new run directly.
// - Same target again: release rising edge with transfer bit starts run.
// - Pushed against loop at standstill with readjust: drive back, set bit 0.
// - Pushed along loop: no readjust, set bit 11, clear bit 0.
// - Zero loop length readjusts in both directions.
// - Readjust starts on leaving window; no power sets bits 10, 13, no retry.
// - After release abort, no readjust until a later run succeeds.
// - Commands only inside 250 of 256 measured rotations; jog stops at the limits, run targets are not range-checked.
// - Factory state: actual 51200, upper 101200, lower 1200.
// - Release cleared during run aborts it and sets status bit 5.
`timescale 1ns/100ps
`include "psc_defines.svh"
module psc_core #(
  parameter int BLOCK_CYCLES = `PSC_BLOCK_MS * `PSC_MS_CYCLES,
  parameter int MS_CYCLES = `PSC_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] enc_pos,
  input wire logic [15:0] speed_fb,
  input wire logic power_ok,
  input wire logic at_setpoint,
  output psc_pkg::psc_drive_t drive_cmd,
  output logic drive_run,
  output logic drive_hold
);
  logic [15:0] ctrl;
  logic [31:0] target;
  logic [31:0] loop_len;
  logic [15:0] status;
  logic [15:0] spd_pos;
  logic [15:0] spd_man;
  logic [15:0] acc_max;
  logic [15:0] dec_max;
  logic [15:0] tq_start;
  logic [15:0] tq_drive;
  logic [15:0] tq_hold;
  logic [15:0] start_ms;
  logic [15:0] pos_window;
  logic [31:0] upper_lim;
  logic [31:0] lower_lim;
  logic [31:0] actual;
  logic [31:0] last_target;
  logic [6:0] block_pct;
  psc_pkg::psc_state_t state;
  logic prev_release;
  logic prev_ack;
  logic new_target;
  logic last_looped;
  logic readj_ok;
  logic readj_dead;
  logic [31:0] start_cnt;
  logic [31:0] block_cnt;
  logic [15:0] dec_now;
  logic wr_go;
  logic [31:0] delta;
  logic loop_fwd;
  logic release_b;
  logic rel_rise;
  logic run_req;
  logic limit_bad;
  logic slow;
  logic out_window;
  logic displ_against;

  // Signed difference used for direction and window tests
  function automatic logic [31:0] diff(input logic [31:0] a, input logic [31:0] b);
    diff = a - b;
  endfunction : diff

  // Magnitude of a signed word
  function automatic logic [31:0] mag(input logic [31:0] a);
    mag = a[31] ? (32'h0 - a) : a;
  endfunction : mag

  // Byte lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // Decoded conditions
  assign release_b = ctrl[`PSC_C_RELEASE];
  assign rel_rise = release_b & ~prev_release;
  assign loop_fwd = loop_len[31]; // Negative loop means forward approach
  assign delta = diff(target, actual);
  assign limit_bad = ((target == upper_lim) && !loop_len[31] && (loop_len != 32'h0)) ||
                     ((target == lower_lim) && loop_len[31]);
  assign slow = ({16'h0, speed_fb} * 32'd100) < ({16'h0, drive_cmd.speed} * {25'h0, block_pct});
  assign out_window = mag(diff(actual, last_target)) > {16'h0, pos_window};
  // Displacement against loop direction or any with zero loop
  assign displ_against = (loop_len == 32'h0) ? 1'b1 :
                         (loop_fwd ? diff(actual, last_target) >= 32'h8000_0000
                                   : diff(actual, last_target) < 32'h8000_0000);
  assign run_req = release_b && (new_target || (rel_rise && ctrl[`PSC_C_XFER]));

  // Bus slave: one wait cycle on every access
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end
  assign wr_go = avs_write && !avs_waitrequest;

  // Read data mux, unmapped words read zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `PSC_REG_CTRL: avs_readdata <= {16'h0, ctrl};
        `PSC_REG_TARGET: avs_readdata <= target;
        `PSC_REG_ACTUAL: avs_readdata <= actual;
        `PSC_REG_LOOP: avs_readdata <= loop_len;
        `PSC_REG_STATUS: avs_readdata <= {16'h0, status};
        `PSC_REG_SPD_POS: avs_readdata <= {16'h0, spd_pos};
        `PSC_REG_SPD_MAN: avs_readdata <= {16'h0, spd_man};
        `PSC_REG_ACCEL: avs_readdata <= {dec_max, acc_max};
        `PSC_REG_TORQUE: avs_readdata <= {tq_drive, tq_start};
        `PSC_REG_START_T: avs_readdata <= {tq_hold, start_ms};
        `PSC_REG_WINDOW: avs_readdata <= {9'h0, block_pct, pos_window};
        `PSC_REG_LIMITS: avs_readdata <= upper_lim;
        `PSC_REG_DRIVE: avs_readdata <= lower_lim;
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // Parameter registers; limits hold the 250-rotation command range
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl <= 16'h0;
      loop_len <= `PSC_RST_LOOP;
      spd_pos <= `PSC_RST_SPD;
      spd_man <= `PSC_RST_SPD;
      acc_max <= `PSC_RST_ACC;
      dec_max <= `PSC_RST_ACC;
      tq_start <= 16'h0;
      tq_drive <= 16'h0;
      tq_hold <= 16'h0;
      start_ms <= `PSC_RST_START_MS;
      pos_window <= `PSC_RST_WINDOW;
      block_pct <= `PSC_RST_BLOCK_PCT;
      upper_lim <= `PSC_RST_UPPER;
      lower_lim <= `PSC_RST_LOWER;
    end else if (wr_go) begin
      case (avs_address)
        `PSC_REG_CTRL: ctrl <= 16'(merge({16'h0, ctrl}, avs_writedata, avs_byteenable));
        `PSC_REG_LOOP: loop_len <= merge(loop_len, avs_writedata, avs_byteenable);
        `PSC_REG_SPD_POS: spd_pos <= avs_writedata[15:0];
        `PSC_REG_SPD_MAN: spd_man <= avs_writedata[15:0];
        `PSC_REG_ACCEL: {dec_max, acc_max} <= avs_writedata;
        `PSC_REG_TORQUE: {tq_drive, tq_start} <= avs_writedata;
        `PSC_REG_START_T: {tq_hold, start_ms} <= avs_writedata;
        `PSC_REG_WINDOW: {block_pct, pos_window} <= avs_writedata[22:0];
        `PSC_REG_LIMITS: upper_lim <= avs_writedata;
        `PSC_REG_DRIVE: lower_lim <= avs_writedata;
        default: ;
      endcase
    end
  end

  // Target register; a changed value flags a new run
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      target <= `PSC_RST_ACTUAL;
      new_target <= 1'b0;
    end else begin
      new_target <= 1'b0;
      if (wr_go && avs_address == `PSC_REG_TARGET) begin
        target <= avs_writedata;
        new_target <= (avs_writedata != target);
      end
    end
  end

  // Actual position follows the encoder
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      actual <= `PSC_RST_ACTUAL;
      prev_release <= 1'b0;
      prev_ack <= 1'b0;
    end else begin
      actual <= enc_pos;
      prev_release <= release_b;
      prev_ack <= ctrl[`PSC_C_ACK];
    end
  end

  // Sequencer: choose pre-move setpoint, final approach, hold and readjust
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= psc_pkg::PSC_IDLE;
      drive_cmd <= '0;
      drive_run <= 1'b0;
      drive_hold <= 1'b0;
      last_looped <= 1'b0;
      last_target <= `PSC_RST_ACTUAL;
      start_cnt <= 32'h0;
      block_cnt <= 32'h0;
    end else begin
      case (state)
        psc_pkg::PSC_IDLE, psc_pkg::PSC_HOLD: begin
          drive_run <= 1'b0;
          if (run_req && !limit_bad) begin
            drive_cmd.speed <= spd_pos;
            drive_cmd.accel <= acc_max;
            drive_cmd.decel <= dec_max;
            drive_cmd.torque <= tq_start;
            start_cnt <= 32'h0;
            block_cnt <= 32'h0;
            drive_run <= 1'b1;
            drive_hold <= 1'b0;
            last_target <= target;
            if (ctrl[`PSC_C_NOLOOP] || loop_len == 32'h0) begin
              drive_cmd.setpoint <= target;
              last_looped <= 1'b0;
              state <= psc_pkg::PSC_FINAL;
            end else if ((loop_fwd ? delta[31] : !delta[31] && delta != 32'h0)) begin
              drive_cmd.setpoint <= target + loop_len;
              last_looped <= 1'b1;
              state <= psc_pkg::PSC_PRE;
            end else if (!last_looped && mag(delta) < mag(loop_len)) begin
              drive_cmd.setpoint <= target + loop_len;
              last_looped <= 1'b1;
              state <= psc_pkg::PSC_PRE;
            end else begin
              drive_cmd.setpoint <= target;
              last_looped <= 1'b1;
              state <= psc_pkg::PSC_FINAL;
            end
          end else if (release_b && (ctrl[`PSC_C_JOG_UP] || ctrl[`PSC_C_JOG_DN])) begin
            drive_cmd.speed <= spd_man;
            drive_cmd.accel <= acc_max;
            drive_cmd.decel <= dec_max;
            drive_cmd.torque <= tq_start;
            drive_cmd.setpoint <= ctrl[`PSC_C_JOG_UP] ? upper_lim : lower_lim;
            start_cnt <= 32'h0;
            block_cnt <= 32'h0;
            drive_run <= 1'b1;
            last_looped <= 1'b0;
            state <= psc_pkg::PSC_JOG;
          end else if (state == psc_pkg::PSC_HOLD && readj_ok && !readj_dead && release_b &&
                       ctrl[`PSC_C_READJ] && out_window && displ_against && power_ok) begin
            drive_cmd.setpoint <= last_target;
            drive_cmd.torque <= tq_start;
            start_cnt <= 32'h0;
            block_cnt <= 32'h0;
            drive_run <= 1'b1;
            state <= psc_pkg::PSC_READJ;
          end
        end
        psc_pkg::PSC_PRE, psc_pkg::PSC_FINAL, psc_pkg::PSC_READJ, psc_pkg::PSC_JOG: begin
          start_cnt <= start_cnt + 32'h1;
          if (start_cnt >= {16'h0, start_ms} * MS_CYCLES) begin
            drive_cmd.torque <= tq_drive;
          end
          block_cnt <= slow ? block_cnt + 32'h1 : 32'h0;
          // Taper deceleration near the destination
          if (mag(diff(drive_cmd.setpoint, actual)) < {16'h0, pos_window} * 32'd4 &&
              drive_cmd.decel > 16'h1) begin
            drive_cmd.decel <= drive_cmd.decel >> 1;
          end
          if (ctrl[`PSC_C_STOP]) begin
            drive_cmd.decel <= `PSC_RST_DEC_MAX;
            drive_cmd.setpoint <= actual;
            drive_run <= 1'b0;
            state <= psc_pkg::PSC_IDLE;
          end else if (!release_b) begin
            drive_run <= 1'b0;
            state <= psc_pkg::PSC_IDLE;
          end else if (block_cnt >= BLOCK_CYCLES) begin
            drive_run <= 1'b0;
            drive_hold <= 1'b1;
            drive_cmd.torque <= tq_hold;
            state <= psc_pkg::PSC_IDLE;
          end else if (state == psc_pkg::PSC_JOG) begin
            if (!ctrl[`PSC_C_JOG_UP] && !ctrl[`PSC_C_JOG_DN]) begin
              drive_run <= 1'b0;
              state <= psc_pkg::PSC_IDLE;
            end
          end else if (at_setpoint) begin
            if (state == psc_pkg::PSC_PRE) begin
              drive_cmd.setpoint <= last_target;
              drive_cmd.decel <= dec_max;
              state <= psc_pkg::PSC_FINAL;
            end else begin
              drive_run <= 1'b0;
              state <= psc_pkg::PSC_HOLD;
            end
          end
        end
        default: state <= psc_pkg::PSC_IDLE;
      endcase
    end
  end

  // Status word and readjust permission
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      status <= 16'h0;
      readj_ok <= 1'b0;
      readj_dead <= 1'b0;
    end else begin
      status[`PSC_S_POWER] <= power_ok;
      if (ctrl[`PSC_C_ACK] && !prev_ack) begin
        status[`PSC_S_ABORTED] <= 1'b0;
        status[`PSC_S_POS_ERR] <= 1'b0;
        status[`PSC_S_DISPL] <= 1'b0;
        status[`PSC_S_NOPWR] <= 1'b0;
      end
      if (state == psc_pkg::PSC_IDLE || state == psc_pkg::PSC_HOLD) begin
        if (run_req) begin
          status[`PSC_S_REACHED] <= 1'b0;
          readj_dead <= 1'b0;
        end
      end
      if (drive_run && (state != psc_pkg::PSC_IDLE)) begin
        if (!release_b && !ctrl[`PSC_C_STOP]) begin
          status[`PSC_S_ABORTED] <= 1'b1;
          readj_ok <= 1'b0;
        end else if (block_cnt >= BLOCK_CYCLES) begin
          status[`PSC_S_POS_ERR] <= 1'b1;
        end else if (at_setpoint && state != psc_pkg::PSC_PRE &&
                     state != psc_pkg::PSC_JOG) begin
          status[`PSC_S_REACHED] <= 1'b1;
          status[`PSC_S_ENC_ERR] <= (enc_pos != drive_cmd.setpoint);
          readj_ok <= 1'b1;
        end
      end
      if (state == psc_pkg::PSC_HOLD && out_window && readj_ok && !readj_dead) begin
        if (!displ_against) begin
          status[`PSC_S_DISPL] <= 1'b1;
          status[`PSC_S_REACHED] <= 1'b0;
        end else if (release_b && ctrl[`PSC_C_READJ] && !power_ok) begin
          status[`PSC_S_POS_ERR] <= 1'b1;
          status[`PSC_S_NOPWR] <= 1'b1;
          readj_dead <= 1'b1;
        end
      end
    end
  end

  // Blocking that reaches the full blocking time aborts the run in the next cycle
  block_abort_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (drive_run && block_cnt >= BLOCK_CYCLES && release_b && !ctrl[`PSC_C_STOP]) |=>
    (!drive_run && drive_hold && status[`PSC_S_POS_ERR]))
    else $error("blocking did not abort the run");

  // Release dropped mid run sets the abort flag
  release_abort_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (drive_run && state != psc_pkg::PSC_IDLE && !release_b && !ctrl[`PSC_C_STOP]) |=>
    (status[`PSC_S_ABORTED] && !drive_run))
    else $error("release abort not flagged");

  // Stop selects the hardest braking
  stop_brake_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (drive_run && ctrl[`PSC_C_STOP]) |=> (drive_cmd.decel == `PSC_RST_DEC_MAX))
    else $error("stop did not use maximum deceleration");

  // Run start always begins with the starting torque
  start_torque_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(drive_run) |-> (drive_cmd.torque == tq_start))
    else $error("run started without starting torque");

  // Pre-move lands one loop length beyond target
  pre_setpoint_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state == psc_pkg::PSC_PRE && $changed(state)) |->
    (drive_cmd.setpoint == last_target + loop_len))
    else $error("overshoot setpoint wrong");

  // No-loop mode never enters the pre-move
  no_loop_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((state == psc_pkg::PSC_IDLE || state == psc_pkg::PSC_HOLD) && run_req &&
     ctrl[`PSC_C_NOLOOP] && !limit_bad) |=>
    (state == psc_pkg::PSC_FINAL))
    else $error("no-loop run took a loop");

  // Limit targets refused with the wrong loop sign
  limit_refuse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((state == psc_pkg::PSC_IDLE || state == psc_pkg::PSC_HOLD) && limit_bad &&
     !ctrl[`PSC_C_JOG_UP] && !ctrl[`PSC_C_JOG_DN] && !ctrl[`PSC_C_READJ]) |=> !$rose(drive_run))
    else $error("limit target accepted");

  // Displacement along the loop direction flags and does not move
  displ_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state == psc_pkg::PSC_HOLD && out_window && readj_ok && !readj_dead && !displ_against &&
     !run_req && !ctrl[`PSC_C_JOG_UP] && !ctrl[`PSC_C_JOG_DN]) |=>
    (status[`PSC_S_DISPL] && !status[`PSC_S_REACHED] && state == psc_pkg::PSC_HOLD))
    else $error("displacement handling wrong");
endmodule : psc_core

/* File: shared/psc_defines.svh */
// Constants of the positioning sequence controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
// Register word offsets (byte address = 4 * index)
`define PSC_REG_CTRL 4'h0
`define PSC_REG_TARGET 4'h1
`define PSC_REG_ACTUAL 4'h2
`define PSC_REG_LOOP 4'h3
`define PSC_REG_STATUS 4'h4
`define PSC_REG_SPD_POS 4'h5
`define PSC_REG_SPD_MAN 4'h6
`define PSC_REG_ACCEL 4'h7
`define PSC_REG_DECEL 4'h8
`define PSC_REG_TORQUE 4'h9
`define PSC_REG_START_T 4'hA
`define PSC_REG_WINDOW 4'hB
`define PSC_REG_LIMITS 4'hC
`define PSC_REG_DRIVE 4'hD
// Control word bits
`define PSC_C_XFER 2
`define PSC_C_RELEASE 4
`define PSC_C_NOLOOP 6
`define PSC_C_JOG_UP 8
`define PSC_C_JOG_DN 9
`define PSC_C_STOP 10
`define PSC_C_READJ 11
`define PSC_C_ACK 14
// Status word bits
`define PSC_S_REACHED 0
`define PSC_S_POWER 4
`define PSC_S_ABORTED 5
`define PSC_S_ENC_ERR 9
`define PSC_S_POS_ERR 10
`define PSC_S_DISPL 11
`define PSC_S_NOPWR 13
// Reset values
`define PSC_RST_LOOP 32'hFFFFFF06
`define PSC_RST_ACTUAL 32'h0000C800
`define PSC_RST_UPPER 32'h00018B50
`define PSC_RST_LOWER 32'h000004B0
`define PSC_RST_WINDOW 16'h0004
`define PSC_RST_SPD 16'h1000
`define PSC_RST_ACC 16'h0010
`define PSC_RST_DEC_MAX 16'hFFFF
`define PSC_RST_START_MS 16'h0064
`define PSC_RST_BLOCK_PCT 7'h1E
// Timing
`define PSC_CLK_HZ 40000000
`define PSC_BLOCK_MS 200
`define PSC_MS_CYCLES (`PSC_CLK_HZ / 1000)
`endif

/* File: shared/psc_pkg.sv */
// Types of the positioning sequence controller.
// Assumes psc_defines.svh is reachable on the include path.
`include "psc_defines.svh"
package psc_pkg;
  typedef enum logic [2:0] {
    PSC_IDLE = 3'h0,
    PSC_PRE = 3'h1,
    PSC_FINAL = 3'h3,
    PSC_HOLD = 3'h2,
    PSC_READJ = 3'h6,
    PSC_JOG = 3'h7
  } psc_state_t;
  typedef struct packed {
    logic [31:0] setpoint;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] torque;
  } psc_drive_t;
endpackage : psc_pkg

/* File: tb/psc_stage_model.sv */
// Motion stage model: follows the drive command and reports position and speed.
// Assumes drive_cmd and drive_run are registered outputs of the controller on core_clk.
`timescale 1ns/100ps
module psc_stage_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire psc_pkg::psc_drive_t drive_cmd,
  input wire logic drive_run,
  input wire logic stall,
  input wire logic [31:0] push,
  output logic [31:0] enc_pos,
  output logic [15:0] speed_fb,
  output logic power_ok,
  output logic at_setpoint
);
  logic signed [31:0] diff;
  logic moving;
  // Signed distance to go and whether the shaft can turn this cycle
  assign diff = $signed(drive_cmd.setpoint - enc_pos);
  assign moving = drive_run && !stall && (diff != 32'sh0);
  // Position steps 8 a cycle; a stall freezes it so blocking can be provoked
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      enc_pos <= 32'h0000C800;
    end else if (moving && (diff > 32'sh8 || diff < -32'sh8)) begin
      enc_pos <= (diff > 32'sh0) ? enc_pos + 32'h8 : enc_pos - 32'h8;
    end else if (moving) begin
      enc_pos <= drive_cmd.setpoint;
    end else if (!drive_run) begin
      enc_pos <= enc_pos + push; // External force shifts a standing shaft
    end
  end
  // Speed reads zero whenever the shaft stands, which is what blocking looks for
  assign speed_fb = moving ? drive_cmd.speed : 16'h0;
  assign power_ok = 1'b1; // Supply always present
  assign at_setpoint = (diff == 32'sh0);
endmodule : psc_stage_model

/* File: tb/psc_core_tb.sv */
// Self-checking bench of the positioning controller with a motion stage model.
// Assumes short blocking and millisecond counts set by parameter.
`timescale 1ns/100ps
`include "psc_defines.svh"
module psc_core_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, enc_pos, rd, tgt;
  logic [31:0] seed = 32'h19;
  logic avs_waitrequest, power_ok, at_setpoint, drive_run, drive_hold;
  logic stall = 1'b0;
  logic [31:0] push = 32'h0;
  logic [15:0] speed_fb;
  psc_pkg::psc_drive_t drive_cmd;
  int failures = 0;
  int cmp_count = 0;

  psc_core #(.BLOCK_CYCLES(50), .MS_CYCLES(4)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .enc_pos(enc_pos), .speed_fb(speed_fb),
    .power_ok(power_ok), .at_setpoint(at_setpoint), .drive_cmd(drive_cmd),
    .drive_run(drive_run), .drive_hold(drive_hold));
  psc_stage_model u_stage (.core_clk(core_clk), .rst_b(rst_b), .drive_cmd(drive_cmd),
    .drive_run(drive_run), .stall(stall), .push(push), .enc_pos(enc_pos), .speed_fb(speed_fb),
    .power_ok(power_ok), .at_setpoint(at_setpoint));

  // 40 MHz clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Avalon-MM access: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n == 100) failures++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk

  // Bounded wait: 0 run low, 1 run high, 2 hold high, 3 setpoint at target
  task automatic wt(input int k);
    int n;
    for (n = 0; n < 20000; n++) begin
      @(posedge core_clk);
      if (k == 0 && drive_run === 1'b0) break;
      if (k == 1 && drive_run === 1'b1) break;
      if (k == 2 && drive_hold === 1'b1) break;
      if (k == 3 && drive_cmd.setpoint === tgt) break;
    end
    if (n == 20000) chk("wait", k, 32'hFFFFFFFF);
    repeat (2) @(posedge core_clk);
  endtask : wt

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Watchdog sized well past the longest run sequence
  initial begin
    repeat (90000) @(posedge core_clk);
    failures++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    bus(1'b0, `PSC_REG_LOOP, 32'h0);
    chk("loop", `PSC_RST_LOOP, rd);
    bus(1'b0, `PSC_REG_ACTUAL, 32'h0);
    chk("actual", `PSC_RST_ACTUAL, rd);
    bus(1'b0, 4'hC, 32'h0);
    chk("upper", `PSC_RST_UPPER, rd);
    bus(1'b0, 4'hD, 32'h0);
    chk("lower", `PSC_RST_LOWER, rd);
    bus(1'b1, 4'hE, 32'h12345678);
    bus(1'b0, 4'hE, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    // Forward target: direct approach, positioning speed, start torque then drive
    bus(1'b1, `PSC_REG_TORQUE, 32'h02000300);
    bus(1'b1, `PSC_REG_CTRL, 32'h10);
    tgt = 32'h0000C800 + 32'h1400 + (xs() & 32'h3FF);
    bus(1'b1, `PSC_REG_TARGET, tgt);
    wt(1);
    chk("direct", tgt, drive_cmd.setpoint);
    chk("speed", {16'h0, `PSC_RST_SPD}, {16'h0, drive_cmd.speed});
    chk("start torque", 32'h0300, {16'h0, drive_cmd.torque});
    repeat (500) @(posedge core_clk);
    chk("drive torque", 32'h0200, {16'h0, drive_cmd.torque});
    wt(0);
    bus(1'b0, `PSC_REG_STATUS, 32'h0);
    chk("reached", 32'h1, {31'h0, rd[`PSC_S_REACHED]});
    chk("enc err", 32'h0, {31'h0, rd[`PSC_S_ENC_ERR]});
    $display("test forward done");
    // Backward target: overshoot by the loop length, then forward to it
    tgt = tgt - 32'h7D0 - (xs() & 32'h1FF);
    bus(1'b1, `PSC_REG_TARGET, tgt);
    wt(1);
    chk("overshoot", tgt + `PSC_RST_LOOP, drive_cmd.setpoint);
    wt(3);
    wt(0);
    chk("landed", tgt, enc_pos);
    $display("test loop done");
    // Pushed along the loop: flag only; pushed against it with readjust on: drive back
    push <= 32'h14;
    @(posedge core_clk);
    push <= 32'h0;
    repeat (4) @(posedge core_clk);
    bus(1'b0, `PSC_REG_STATUS, 32'h0);
    chk("displaced", 32'h1, {31'h0, rd[`PSC_S_DISPL]});
    chk("reached cleared", 32'h0, {31'h0, rd[`PSC_S_REACHED]});
    chk("no readjust", 32'h0, {31'h0, drive_run});
    bus(1'b1, `PSC_REG_CTRL, 32'h810);
    push <= 32'hFFFFFFD8;
    @(posedge core_clk);
    push <= 32'h0;
    wt(1);
    wt(0);
    chk("readjusted", tgt, enc_pos);
    bus(1'b0, `PSC_REG_STATUS, 32'h0);
    chk("readj reached", 32'h1, {31'h0, rd[`PSC_S_REACHED]});
    $display("test readjust done");
    // No-loop mode: backward target is approached directly
    bus(1'b1, `PSC_REG_CTRL, 32'h50);
    tgt = tgt - 32'h5DC;
    bus(1'b1, `PSC_REG_TARGET, tgt);
    wt(1);
    chk("noloop", tgt, drive_cmd.setpoint);
    wt(0);
    $display("test noloop done");
    // Clearing release mid-run aborts it
    bus(1'b1, `PSC_REG_CTRL, 32'h10);
    tgt = tgt + 32'h1770;
    bus(1'b1, `PSC_REG_TARGET, tgt);
    wt(1);
    bus(1'b1, `PSC_REG_CTRL, 32'h0);
    wt(0);
    bus(1'b0, `PSC_REG_STATUS, 32'h0);
    chk("aborted", 32'h1, {31'h0, rd[`PSC_S_ABORTED]});
    $display("test abort done");
    // Stalled shaft blocks; a changed target then starts at once
    bus(1'b1, `PSC_REG_CTRL, 32'h10);
    stall <= 1'b1;
    tgt = tgt + 32'hBB8;
    bus(1'b1, `PSC_REG_TARGET, tgt);
    wt(2);
    chk("hold", 32'h1, {31'h0, drive_hold});
    bus(1'b0, `PSC_REG_STATUS, 32'h0);
    chk("pos err", 32'h1, {31'h0, rd[`PSC_S_POS_ERR]});
    stall <= 1'b0;
    tgt = tgt + 32'h7D0;
    bus(1'b1, `PSC_REG_TARGET, tgt);
    wt(1);
    chk("new run", tgt, drive_cmd.setpoint);
    wt(0);
    // Same target after blocking: release edge with transfer bit restarts
    stall <= 1'b1;
    tgt = tgt + 32'hBB8;
    bus(1'b1, `PSC_REG_TARGET, tgt);
    wt(2);
    stall <= 1'b0;
    bus(1'b1, `PSC_REG_CTRL, 32'h0);
    bus(1'b1, `PSC_REG_CTRL, 32'h14);
    wt(1);
    chk("repeat run", tgt, drive_cmd.setpoint);
    wt(0);
    $display("test blocking done");
    // Lower limit target with a negative loop is refused
    bus(1'b1, `PSC_REG_TARGET, `PSC_RST_LOWER);
    repeat (20) @(posedge core_clk);
    chk("limit refused", 32'h0, {31'h0, drive_run});
    $display("test limit done");
    close_out();
  end
endmodule : psc_core_tb
